// ### common/tef_pkg.sv
// Constants, register map and encodings of the timer event-flag block.
package tef_pkg;
    // Widths of the register port and the channel counters.
    localparam int ADDR_W = 5;
    localparam int DATA_W = 16;
    localparam int CNT_W = 16;
    // Number of channels and of compare registers in all.
    localparam int CH_NUM = 3;
    localparam int CC_NUM = 8;
    localparam int SRC_NUM = 13;
    // Register index inside a channel block of eight words.
    localparam logic [2:0] REG_CTRL = 3'h0;
    localparam logic [2:0] REG_IER = 3'h1;
    localparam logic [2:0] REG_STAT = 3'h2;
    localparam logic [2:0] REG_CNT = 3'h3;
    localparam logic [2:0] REG_CMP_A = 3'h4;
    // Control register fields: count mode and per-compare output level.
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_IO_LSB = 2;
    // Status and enable bit positions; overflow and underflow shared by both registers.
    localparam int BIT_OVF = 4;
    localparam int BIT_UNF = 5;
    localparam int BIT_DIR = 7;
    localparam int IER_DTC_LSB = 8;
    localparam int IER_DMA = 12;
    // Reset values.
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [15:0] IER_RST = 16'h0000;
    localparam logic [15:0] CNT_RST = 16'h0000;
    localparam logic [15:0] CMP_RST = 16'hFFFF;
    localparam logic [15:0] RD_ZERO = 16'h0000;
    localparam logic [15:0] CNT_ONE = 16'h0001;
    localparam logic [15:0] CNT_MAX = 16'hFFFF;
    // Counter value below which a down count wraps.
    localparam logic [15:0] CNT_ZERO_W = 16'h0000;
    localparam logic [3:0] SRC_NONE = 4'hF;
    // Count source selection of a channel.
    typedef enum logic [1:0] {
        TEF_STOP = 2'b00,
        TEF_INTERNAL = 2'b01,
        TEF_PHASE3 = 2'b10,
        TEF_PHASE4 = 2'b11
    } tef_mode_e;
    // Level driven on a compare pin at a match.
    typedef enum logic [1:0] {
        TEF_IO_HOLD = 2'b00,
        TEF_IO_LOW = 2'b01,
        TEF_IO_HIGH = 2'b10,
        TEF_IO_TOGGLE = 2'b11
    } tef_io_e;
endpackage : tef_pkg

// ### verilog/tef_timer_events.sv
// Three-channel timer with phase counting, compare outputs and event flags.
// Contract
// - Channel 1 uses pins A/B, channel 2 C/D.
// - Mode 3: up A fall B high, down B fall A high.
// - Mode 4: counts only on phase-B edges.
// - Each source has own flag and enable.
// - Request while flag and enable both set.
// - Fixed priority within channel, channel 0 first.
// - Eight compare sources: four, two, two.
// - One overflow source per channel.
// - Underflow sources only on channels 1, 2.
// - Compare requests may start transfer controller.
// - Only compare A requests start DMA.
// - Match pulse when counter about to update.
// - Match drives pin to selected level.
// - One match per counter input tick.
// - Flag cleared by zero write after read.
// - Transfer or DMA acknowledge clears flag.
// - Phase counting only on channels 1, 2.
// - Wrap up sets overflow, down underflow.
// - Direction flag readable in status.
`timescale 1ns/1ps
`default_nettype none
module tef_timer_events (
    // Clock, reset and clock enable.
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    // Register port.
    input wire logic [tef_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [tef_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [tef_pkg::DATA_W-1:0] reg_rdata,
    // External phase clock pins.
    input wire logic ext_clk_pin_a,
    input wire logic ext_clk_pin_b,
    input wire logic ext_clk_pin_c,
    input wire logic ext_clk_pin_d,
    // Compare output pins, one per compare register.
    output logic [tef_pkg::CC_NUM-1:0] capture_compare_pin,
    // Requests toward the interrupt controller.
    output logic [tef_pkg::CC_NUM-1:0] capture_compare_request,
    output logic [tef_pkg::CH_NUM-1:0] overflow_request,
    output logic [tef_pkg::CH_NUM-2:0] underflow_request,
    output logic [3:0] top_request_src,
    // Transfer controller activation.
    output logic [tef_pkg::CC_NUM-1:0] data_transfer_controller_req,
    input wire logic [tef_pkg::CC_NUM-1:0] data_transfer_controller_ack,
    // DMA controller activation, compare A of each channel.
    output logic [tef_pkg::CH_NUM-1:0] dma_controller_req,
    input wire logic [tef_pkg::CH_NUM-1:0] dma_controller_ack
);
    // Returns the index of the highest-priority pending source.
    function automatic logic [3:0] prio_pick(input logic [tef_pkg::SRC_NUM-1:0] v);
        logic [3:0] r;
        r = tef_pkg::SRC_NONE;
        for (int i = tef_pkg::SRC_NUM - 1; i >= 0; i--)
        begin
            if (v[i])
            begin
                r = 4'(i);
            end
        end
        return r;
    endfunction : prio_pick

    // Returns the new pin level for one output-level code.
    function automatic logic pin_level(input logic [1:0] code, input logic cur);
        logic r;
        case (code)
            tef_pkg::TEF_IO_LOW: r = 1'b0;
            tef_pkg::TEF_IO_HIGH: r = 1'b1;
            tef_pkg::TEF_IO_TOGGLE: r = ~cur;
            default: r = cur;
        endcase
        return r;
    endfunction : pin_level

    // Address split into channel block and register index.
    wire logic [1:0] ch_sel = reg_addr[4:3];
    wire logic [2:0] reg_sel = reg_addr[2:0];

    // Channel state registers.
    logic [15:0] ctrl_ff [tef_pkg::CH_NUM];
    logic [15:0] ier_ff [tef_pkg::CH_NUM];
    logic [15:0] cnt_ff [tef_pkg::CH_NUM];
    logic [15:0] cmp_ff [tef_pkg::CH_NUM][4];
    // Event flags, the "read as one" marks for them, and the direction flags.
    logic [tef_pkg::CC_NUM-1:0] cc_flag_ff;
    logic [tef_pkg::CC_NUM-1:0] cc_seen_ff;
    logic [tef_pkg::CH_NUM-1:0] ovf_flag_ff;
    logic [tef_pkg::CH_NUM-1:0] ovf_seen_ff;
    logic [tef_pkg::CH_NUM-1:0] unf_flag_ff;
    logic [tef_pkg::CH_NUM-1:0] unf_seen_ff;
    logic [tef_pkg::CH_NUM-1:0] dir_ff;
    // Previous samples of each channel's phase inputs.
    logic [tef_pkg::CH_NUM-1:0] pa_ff;
    logic [tef_pkg::CH_NUM-1:0] pb_ff;

    // Per-channel decoded strobes and counting events.
    logic [tef_pkg::CH_NUM-1:0] up_w;
    logic [tef_pkg::CH_NUM-1:0] dn_w;
    logic [tef_pkg::CH_NUM-1:0] cnt_wr_w;
    logic [tef_pkg::CH_NUM-1:0] stat_wr_w;
    logic [tef_pkg::CH_NUM-1:0] stat_rd_w;
    logic [tef_pkg::CH_NUM-1:0] ovf_set_w;
    logic [tef_pkg::CH_NUM-1:0] unf_set_w;
    logic [tef_pkg::CC_NUM-1:0] match_w;
    logic [tef_pkg::CC_NUM-1:0] cc_en_w;
    logic [tef_pkg::CC_NUM-1:0] dtc_en_w;
    logic [tef_pkg::CH_NUM-1:0] dma_en_w;
    logic [tef_pkg::CH_NUM-1:0] dma_flag_w;
    logic [15:0] ch_rd_w [tef_pkg::CH_NUM];

    // Channels are built alike; channel 0 has four compares and no phase mode.
    for (genvar c = 0; c < tef_pkg::CH_NUM; c++)
    begin : g_ch
        localparam int NCC = (c == 0) ? 4 : 2;
        localparam int BASE = (c == 0) ? 0 : 2 * c + 2;
        // Write and read strobes of this channel.
        wire logic hit = ce && (ch_sel == 2'(c));
        wire logic ctrl_wr = hit && reg_wr && (reg_sel == tef_pkg::REG_CTRL);
        wire logic ier_wr = hit && reg_wr && (reg_sel == tef_pkg::REG_IER);
        wire logic [1:0] mode = ctrl_ff[c][tef_pkg::CTRL_MODE_LSB +: 2];
        // Phase pins: channel 1 takes A/B, channel 2 takes C/D.
        wire logic pa = (c == 1) ? ext_clk_pin_a : ext_clk_pin_c;
        wire logic pb = (c == 1) ? ext_clk_pin_b : ext_clk_pin_d;
        // Edges found by comparing the new sample with the last one.
        wire logic a_fall = pa_ff[c] && !pa;
        wire logic b_fall = pb_ff[c] && !pb;
        wire logic b_rise = !pb_ff[c] && pb;
        // Mode 3 counts on A falling with B high, down on B falling with A high.
        wire logic up3 = (mode == tef_pkg::TEF_PHASE3) && a_fall && pb;
        wire logic dn3 = (mode == tef_pkg::TEF_PHASE3) && b_fall && pa;
        // Mode 4 counts only on B edges, direction from the A level.
        wire logic up4 = (mode == tef_pkg::TEF_PHASE4) && ((b_rise && pa) || (b_fall && !pa));
        wire logic dn4 = (mode == tef_pkg::TEF_PHASE4) && ((b_fall && pa) || (b_rise && !pa));
        // Phase modes take effect only on channels 1 and 2.
        wire logic phase_ok = (c != 0);
        assign up_w[c] = (mode == tef_pkg::TEF_INTERNAL) || (phase_ok && (up3 || up4));
        assign dn_w[c] = phase_ok && (dn3 || dn4);
        assign cnt_wr_w[c] = hit && reg_wr && (reg_sel == tef_pkg::REG_CNT);
        assign stat_wr_w[c] = hit && reg_wr && (reg_sel == tef_pkg::REG_STAT);
        assign stat_rd_w[c] = hit && reg_rd && (reg_sel == tef_pkg::REG_STAT);
        // A counter write wins over counting and suppresses wrap flags.
        assign ovf_set_w[c] = up_w[c] && !cnt_wr_w[c] && (cnt_ff[c] == tef_pkg::CNT_MAX);
        assign unf_set_w[c] = phase_ok && dn_w[c] && !cnt_wr_w[c] && (cnt_ff[c] == tef_pkg::CNT_ZERO_W);
        // Enable and flag of the DMA source of compare A.
        assign dma_en_w[c] = ier_ff[c][tef_pkg::IER_DMA];
        assign dma_flag_w[c] = cc_flag_ff[BASE];

        // Control, enable and counter registers of the channel.
        always_ff @(posedge clk or negedge nrst)
        begin
            if (!nrst)
            begin
                ctrl_ff[c] <= tef_pkg::CTRL_RST;
                ier_ff[c] <= tef_pkg::IER_RST;
                cnt_ff[c] <= tef_pkg::CNT_RST;
                pa_ff[c] <= 1'b0;
                pb_ff[c] <= 1'b0;
                dir_ff[c] <= 1'b1;
            end
            else if (ce)
            begin
                ctrl_ff[c] <= ctrl_wr ? reg_wdata : ctrl_ff[c];
                ier_ff[c] <= ier_wr ? reg_wdata : ier_ff[c];
                pa_ff[c] <= pa;
                pb_ff[c] <= pb;
                if (cnt_wr_w[c])
                begin
                    cnt_ff[c] <= reg_wdata;
                end
                else if (up_w[c])
                begin
                    cnt_ff[c] <= cnt_ff[c] + tef_pkg::CNT_ONE;
                    dir_ff[c] <= 1'b1;
                end
                else if (dn_w[c])
                begin
                    cnt_ff[c] <= cnt_ff[c] - tef_pkg::CNT_ONE;
                    dir_ff[c] <= 1'b0;
                end
            end
        end

        // Overflow and underflow flags; set wins over a clear in the same cycle.
        wire logic ovf_clr = stat_wr_w[c] && ovf_seen_ff[c] && !reg_wdata[tef_pkg::BIT_OVF];
        wire logic unf_clr = stat_wr_w[c] && unf_seen_ff[c] && !reg_wdata[tef_pkg::BIT_UNF];
        always_ff @(posedge clk or negedge nrst)
        begin
            if (!nrst)
            begin
                ovf_flag_ff[c] <= 1'b0;
                ovf_seen_ff[c] <= 1'b0;
                unf_flag_ff[c] <= 1'b0;
                unf_seen_ff[c] <= 1'b0;
            end
            else if (ce)
            begin
                ovf_flag_ff[c] <= ovf_set_w[c] || (ovf_flag_ff[c] && !ovf_clr);
                unf_flag_ff[c] <= unf_set_w[c] || (unf_flag_ff[c] && !unf_clr);
                ovf_seen_ff[c] <= stat_rd_w[c] ? ovf_flag_ff[c] : (ovf_seen_ff[c] && !ovf_clr);
                unf_seen_ff[c] <= stat_rd_w[c] ? unf_flag_ff[c] : (unf_seen_ff[c] && !unf_clr);
            end
        end

        // One compare register, flag and output pin per compare source.
        for (genvar k = 0; k < 4; k++)
        begin : g_cc
            if (k < NCC)
            begin : g_on
                localparam int IDX = BASE + k;
                wire logic cmp_wr = hit && reg_wr && (reg_sel == tef_pkg::REG_CMP_A + 3'(k));
                // Match only in the last cycle of equality, at a counter tick.
                assign match_w[IDX] = (up_w[c] || dn_w[c]) && !cmp_wr
                                      && (cnt_ff[c] == cmp_ff[c][k]);
                assign cc_en_w[IDX] = ier_ff[c][k];
                assign dtc_en_w[IDX] = ier_ff[c][tef_pkg::IER_DTC_LSB + k];
                // Clear by zero write after read, or by a controller acknowledge.
                wire logic ack = data_transfer_controller_ack[IDX]
                                 || ((k == 0) && dma_controller_ack[c]);
                wire logic cpu_clr = stat_wr_w[c] && cc_seen_ff[IDX] && !reg_wdata[k];
                wire logic [1:0] io = ctrl_ff[c][tef_pkg::CTRL_IO_LSB + 2 * k +: 2];
                always_ff @(posedge clk or negedge nrst)
                begin
                    if (!nrst)
                    begin
                        cmp_ff[c][k] <= tef_pkg::CMP_RST;
                        cc_flag_ff[IDX] <= 1'b0;
                        cc_seen_ff[IDX] <= 1'b0;
                        capture_compare_pin[IDX] <= 1'b0;
                    end
                    else if (ce)
                    begin
                        cmp_ff[c][k] <= cmp_wr ? reg_wdata : cmp_ff[c][k];
                        cc_flag_ff[IDX] <= match_w[IDX]
                                           || (cc_flag_ff[IDX] && !cpu_clr && !ack);
                        cc_seen_ff[IDX] <= stat_rd_w[c] ? cc_flag_ff[IDX]
                                                        : (cc_seen_ff[IDX] && !cpu_clr && !ack);
                        if (match_w[IDX])
                        begin
                            capture_compare_pin[IDX] <= pin_level(io, capture_compare_pin[IDX]);
                        end
                    end
                end
            end
            else
            begin : g_off
                // Unused compare slot of channels 1 and 2.
                assign cmp_ff[c][k] = tef_pkg::RD_ZERO;
            end
        end

        // Readback word of the channel; unbuilt registers read as zero.
        wire logic [15:0] stat_word = {8'h00, dir_ff[c], 1'b0, unf_flag_ff[c], ovf_flag_ff[c],
                                       (c == 0) ? cc_flag_ff[3:0]
                                                : {2'b00, cc_flag_ff[BASE +: 2]}};
        assign ch_rd_w[c] = (reg_sel == tef_pkg::REG_CTRL) ? ctrl_ff[c]
                          : (reg_sel == tef_pkg::REG_IER) ? ier_ff[c]
                          : (reg_sel == tef_pkg::REG_STAT) ? stat_word
                          : (reg_sel == tef_pkg::REG_CNT) ? cnt_ff[c]
                          : cmp_ff[c][reg_sel[1:0]];
    end

    // Priority vector, highest first: A..D, overflow, then underflow per channel.
    wire logic [tef_pkg::CC_NUM-1:0] cc_req_w = cc_flag_ff & cc_en_w;
    wire logic [tef_pkg::CH_NUM-1:0] ovf_req_w;
    wire logic [tef_pkg::CH_NUM-1:0] unf_req_w;
    for (genvar c = 0; c < tef_pkg::CH_NUM; c++)
    begin : g_req
        assign ovf_req_w[c] = ovf_flag_ff[c] && ier_ff[c][tef_pkg::BIT_OVF];
        assign unf_req_w[c] = unf_flag_ff[c] && ier_ff[c][tef_pkg::BIT_UNF] && (c != 0);
    end
    wire logic [tef_pkg::SRC_NUM-1:0] prio_vec = {unf_req_w[2], ovf_req_w[2], cc_req_w[7:6],
                                                  unf_req_w[1], ovf_req_w[1], cc_req_w[5:4],
                                                  ovf_req_w[0], cc_req_w[3:0]};
    wire logic [15:0] rd_val = (ch_sel < 2'(tef_pkg::CH_NUM)) ? ch_rd_w[ch_sel] : tef_pkg::RD_ZERO;

    // Registered outputs: requests, activation, priority and read data.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            capture_compare_request <= '0;
            overflow_request <= '0;
            underflow_request <= '0;
            top_request_src <= tef_pkg::SRC_NONE;
            data_transfer_controller_req <= '0;
            dma_controller_req <= '0;
            reg_rdata <= tef_pkg::RD_ZERO;
        end
        else if (ce)
        begin
            capture_compare_request <= cc_req_w;
            overflow_request <= ovf_req_w;
            underflow_request <= unf_req_w[2:1];
            top_request_src <= prio_pick(prio_vec);
            data_transfer_controller_req <= cc_flag_ff & dtc_en_w;
            dma_controller_req <= dma_flag_w & dma_en_w;
            reg_rdata <= reg_rd ? rd_val : tef_pkg::RD_ZERO;
        end
    end

    // Mode 3 on channel 1: A falling with B high adds one.
    sequence s_m3_up;
        ce && ctrl_ff[1][1:0] == tef_pkg::TEF_PHASE3 && pa_ff[1] && !ext_clk_pin_a
        && ext_clk_pin_b && !cnt_wr_w[1];
    endsequence
    property p_m3_up;
        @(posedge clk) disable iff (!nrst)
        s_m3_up |=> cnt_ff[1] == $past(cnt_ff[1]) + tef_pkg::CNT_ONE;
    endproperty
    a_m3_up: assert property (p_m3_up) else $error("Mode 3 up count missed.");

    // Mode 4 on channel 2: A edges alone never move the counter.
    property p_m4_a_only;
        @(posedge clk) disable iff (!nrst)
        ce && ctrl_ff[2][1:0] == tef_pkg::TEF_PHASE4 && pb_ff[2] == ext_clk_pin_d
        && !cnt_wr_w[2] |=> $stable(cnt_ff[2]);
    endproperty
    a_m4_a_only: assert property (p_m4_a_only) else $error("Mode 4 counted without B edge.");

    // Enabled overflow flag raises the request on the next edge and holds it.
    sequence s_ovf_pend;
        ce && ovf_flag_ff[1] && ier_ff[1][tef_pkg::BIT_OVF];
    endsequence
    property p_ovf_req;
        @(posedge clk) disable iff (!nrst)
        s_ovf_pend ##1 s_ovf_pend |-> overflow_request[1];
    endproperty
    a_ovf_req: assert property (p_ovf_req) else $error("Overflow request not raised.");

    // Channel 0 never shows an underflow flag.
    property p_no_unf0;
        @(posedge clk) disable iff (!nrst)
        1'b1 |-> !unf_flag_ff[0];
    endproperty
    a_no_unf0: assert property (p_no_unf0) else $error("Underflow flag on channel 0.");

    // A DMA request only follows a pending compare A flag.
    property p_dma_src;
        @(posedge clk) disable iff (!nrst)
        dma_controller_req[0] |-> $past(cc_flag_ff[0]) && $past(ier_ff[0][tef_pkg::IER_DMA]);
    endproperty
    a_dma_src: assert property (p_dma_src) else $error("DMA request without compare A.");

    // A match is taken only where the counter value moves on.
    property p_match_tick;
        @(posedge clk) disable iff (!nrst)
        ce && match_w[0] && !cnt_wr_w[0] |=> cnt_ff[0] != $past(cnt_ff[0]);
    endproperty
    a_match_tick: assert property (p_match_tick) else $error("Match without counter tick.");

    // An acknowledge with no new event leaves the flag clear.
    property p_ack_clr;
        @(posedge clk) disable iff (!nrst)
        ce && data_transfer_controller_ack[0] && !match_w[0] |=> !cc_flag_ff[0];
    endproperty
    a_ack_clr: assert property (p_ack_clr) else $error("Acknowledge did not clear flag.");

    // An event in the cycle of a clear keeps the flag set.
    property p_set_wins;
        @(posedge clk) disable iff (!nrst)
        ce && ovf_set_w[1] && stat_wr_w[1] |=> ovf_flag_ff[1];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("Event lost against clear.");

    // A zero write without an earlier read of one leaves the flag set.
    property p_need_read;
        @(posedge clk) disable iff (!nrst)
        ce && ovf_flag_ff[2] && !ovf_seen_ff[2] && stat_wr_w[2] |=> ovf_flag_ff[2];
    endproperty
    a_need_read: assert property (p_need_read) else $error("Flag cleared without read.");
endmodule : tef_timer_events
`default_nettype wire

// ### bench/tef_xfer_partner.sv
// Far-side model that acknowledges transfer and DMA activation requests.
`timescale 1ns/1ps
`default_nettype none
module tef_xfer_partner (
    // Clock, reset and pacing.
    input wire logic clk,
    input wire logic nrst,
    input wire logic slow,
    // Activation requests and their acknowledges.
    input wire logic [7:0] dtc_req,
    input wire logic [2:0] dma_req,
    output logic [7:0] dtc_ack,
    output logic [2:0] dma_ack
);
    // Delay counter; negative values are a holdoff while the request drops.
    int wait_ff;
    // Acks pulse one cycle after a prompt or slow delay, then hold off.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wait_ff <= 0;
            dtc_ack <= 8'h00;
            dma_ack <= 3'h0;
        end
        else
        begin
            dtc_ack <= 8'h00;
            dma_ack <= 3'h0;
            if (wait_ff < 0)
                wait_ff <= wait_ff + 1;
            else if (!(|{dtc_req, dma_req}))
                wait_ff <= 0;
            else if (wait_ff == (slow ? 6 : 0))
            begin
                dtc_ack <= dtc_req;
                dma_ack <= dma_req;
                wait_ff <= -4;
            end
            else
                wait_ff <= wait_ff + 1;
        end
    end
endmodule : tef_xfer_partner
`default_nettype wire

// ### bench/tef_timer_events_tb.sv
// Self-checking bench of the timer event block with a phase-count model.
`timescale 1ns/1ps
`default_nettype none
module tef_timer_events_tb;
    // Stimulus, design outputs and bench state.
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic slow = 1'b0;
    logic [4:0] reg_addr = 5'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic pa = 1'b0, pb = 1'b0, pc = 1'b0, pd = 1'b0;
    logic [15:0] reg_rdata, rd_val;
    logic [7:0] cc_pin, cc_req, dtc_req, dtc_ack;
    logic [2:0] ovf_req, dma_req, dma_ack;
    logic [1:0] unf_req;
    logic [3:0] top_src;
    int error_cnt = 0;
    int comparisons = 0;
    int seed = 32'hcbf2;
    int cnt [1:2];
    logic [15:0] flg [1:2];
    // The clock toggles every half period of 2.5 ns.
    always #2.5 clk = ~clk;
    tef_timer_events u_dut (.clk(clk), .nrst(nrst), .ce(1'b1), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .ext_clk_pin_a(pa), .ext_clk_pin_b(pb), .ext_clk_pin_c(pc), .ext_clk_pin_d(pd),
        .capture_compare_pin(cc_pin), .capture_compare_request(cc_req),
        .overflow_request(ovf_req), .underflow_request(unf_req), .top_request_src(top_src),
        .data_transfer_controller_req(dtc_req), .data_transfer_controller_ack(dtc_ack),
        .dma_controller_req(dma_req), .dma_controller_ack(dma_ack));
    tef_xfer_partner u_partner (.clk(clk), .nrst(nrst), .slow(slow), .dtc_req(dtc_req),
        .dma_req(dma_req), .dtc_ack(dtc_ack), .dma_ack(dma_ack));
    // Word index of a register of a channel.
    function automatic logic [4:0] ad(input logic [1:0] ch, input logic [2:0] r);
        return {ch, r};
    endfunction : ad
    // Counts a comparison and reports a mismatch.
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp)
        begin
            $display("unexpected %s expected %h seen %h", what, exp, got);
            error_cnt++;
        end
    endtask : chk
    // One-cycle register write.
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    // One-cycle register read; the data stand in the following cycle.
    task automatic rd(input logic [4:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 rd_val = reg_rdata;
    endtask : rd
    // Model of one counter tick: match at all-ones, wrap flags, direction.
    task automatic step(input int ch, input logic up, input logic dn);
        if (up || dn)
        begin
            if (cnt[ch] == 65535) flg[ch][1:0] = 2'b11;
            if (up && cnt[ch] == 65535) flg[ch][4] = 1'b1;
            if (dn && cnt[ch] == 0) flg[ch][5] = 1'b1;
            cnt[ch] = up ? (cnt[ch] + 1) % 65536 : (cnt[ch] + 65535) % 65536;
            flg[ch][7] = up;
        end
    endtask : step
    // Prints the counts and the verdict, then ends the run.
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : finish_test
    // Main sequence: reset values, phase counting with flags, compare match with acks.
    initial
    begin
        logic na, nb, nc, nd;
        logic [31:0] r;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        rd(ad(2'd0, tef_pkg::REG_STAT));
        chk("ch0 status", 16'h0080, rd_val);
        rd(ad(2'd0, tef_pkg::REG_CMP_A));
        chk("ch0 compare a", tef_pkg::CMP_RST, rd_val);
        rd(ad(2'd3, tef_pkg::REG_STAT));
        chk("unmapped read", tef_pkg::RD_ZERO, rd_val);
        chk("idle source", {12'h000, tef_pkg::SRC_NONE}, {12'h000, top_src});
        $display("test reset done");
        cnt[1] = 1;
        cnt[2] = 65534;
        flg[1] = 16'h0080;
        flg[2] = 16'h0080;
        wr(ad(2'd1, tef_pkg::REG_CNT), 16'h0001);
        wr(ad(2'd2, tef_pkg::REG_CNT), 16'hfffe);
        wr(ad(2'd1, tef_pkg::REG_IER), 16'h0030);
        wr(ad(2'd1, tef_pkg::REG_CTRL), {14'h0000, tef_pkg::TEF_PHASE3});
        wr(ad(2'd2, tef_pkg::REG_CTRL), {14'h0000, tef_pkg::TEF_PHASE4});
        // Each cycle one phase pin of each channel toggles at random.
        for (int i = 0; i < 400; i++)
        begin
            @(posedge clk);
            r = $random(seed);
            na = pa ^ r[0];
            nb = pb ^ !r[0];
            nc = pc ^ r[1];
            nd = pd ^ !r[1];
            step(1, pa & !na & nb, pb & !nb & na);
            step(2, (!pd & nd & nc) | (pd & !nd & !nc), (pd & !nd & nc) | (!pd & nd & !nc));
            pa <= na;
            pb <= nb;
            pc <= nc;
            pd <= nd;
        end
        repeat (3) @(posedge clk);
        wr(ad(2'd2, tef_pkg::REG_STAT), 16'h0000);
        for (int ch = 1; ch < 3; ch++)
        begin
            rd(ad(ch[1:0], tef_pkg::REG_CNT));
            chk("phase counter", cnt[ch][15:0], rd_val);
            rd(ad(ch[1:0], tef_pkg::REG_STAT));
            chk("phase status", flg[ch], rd_val);
        end
        chk("ch1 wrap requests", {14'h0000, flg[1][5:4]}, {14'h0000, unf_req[0], ovf_req[1]});
        chk("wrap source", flg[1][4] ? 16'h0007 : flg[1][5] ? 16'h0008 : 16'h000f,
            {12'h000, top_src});
        for (int ch = 1; ch < 3; ch++)
        begin
            wr(ad(ch[1:0], tef_pkg::REG_STAT), 16'h0000);
            rd(ad(ch[1:0], tef_pkg::REG_STAT));
            chk("cleared status", flg[ch] & 16'h0080, rd_val);
        end
        chk("dropped requests", 16'h0000, {11'h000, ovf_req, unf_req});
        $display("test phase counting done");
        // Pin levels at the match: high, then low, then toggle.
        for (int k = 0; k < 3; k++)
        begin
            slow <= k[0];
            wr(ad(2'd0, tef_pkg::REG_IER), 16'h1101);
            wr(ad(2'd0, tef_pkg::REG_CMP_A), 16'h0014);
            wr(ad(2'd0, tef_pkg::REG_CNT), 16'h0000);
            wr(ad(2'd0, tef_pkg::REG_CTRL), (k == 0) ? 16'h0009 : (k == 1) ? 16'h0005 : 16'h000d);
            for (int i = 0; i < 60 && cc_pin[0] !== (k != 1); i++) @(posedge clk) #1;
            chk("ch0 pin a", {15'h0000, k != 1}, {15'h0000, cc_pin[0]});
            for (int i = 0; i < 4 && cc_req[0] !== 1'b1; i++) @(posedge clk) #1;
            chk("ch0 requests", 16'he000, {cc_req[0], dtc_req[0], dma_req[0], dtc_req[7:1],
                2'b00, top_src});
            for (int i = 0; i < 30 && cc_req[0] !== 1'b0; i++) @(posedge clk) #1;
            chk("auto clear", 16'h0000, {15'h0000, cc_req[0]});
            wr(ad(2'd0, tef_pkg::REG_CTRL), 16'h0000);
        end
        $display("test compare match done");
        finish_test();
    end
endmodule : tef_timer_events_tb
`default_nettype wire
